// file: inc/mem_event_pkg.sv
// Purpose: Shared constants and types for the memory-path event counting block
// Assumes: All event sources and counter selections run on sys_clk
// Notes:   Event codes and unit mask bits are the values the counter selection logic programs
package mem_event_pkg;

   // Event codes
   localparam logic [7:0] EV_PRIORITY_UPDATE = 8'h31;
   localparam logic [7:0] EV_MEM_RETRY       = 8'h32;
   localparam logic [7:0] EV_FORCED_ACK      = 8'h33;
   localparam logic [7:0] EV_SLEEP           = 8'h34;

   // Unit masks used by the channel, destination and sleep cause groups
   localparam logic [7:0] MASK_FIRST         = 8'h01;
   localparam logic [7:0] MASK_SECOND        = 8'h02;
   localparam logic [7:0] MASK_THIRD         = 8'h04;
   localparam logic [7:0] MASK_ANY_OF_THREE  = 8'h07;
   localparam logic [7:0] MASK_HUB_ADDRESS   = 8'h08;
   localparam logic [7:0] MASK_REMOTE_ADDR   = 8'h10;
   localparam logic [7:0] MASK_LOCAL_ADDR    = 8'h20;

   // Hit vector bit positions for the sleep causes
   localparam int SLEEP_HUB_ORDER    = 0;
   localparam int SLEEP_REMOTE_ORDER = 1;
   localparam int SLEEP_LOCAL_ORDER  = 2;
   localparam int SLEEP_HUB_ADDR     = 3;
   localparam int SLEEP_REMOTE_ADDR  = 4;
   localparam int SLEEP_LOCAL_ADDR   = 5;

   // Sizes
   localparam int NUM_CTR  = 4;
   localparam int COUNT_W  = 48;
   localparam int NUM_CHAN = 3;
   localparam int CHAN_W   = 2;
   localparam int HIT_W    = 6;
   localparam int INC_W    = 3;
   localparam int SLOTS    = 8;
   localparam int SLOT_W   = 3;
   localparam int TAG_W    = 8;

   localparam logic [COUNT_W-1:0] COUNT_RESET = 48'h0;

   typedef enum logic [1:0] {class_normal, class_high, class_critical} isochronous_class_e;

endpackage

// file: src/event_counter.sv
// Purpose: One accumulating event counter
// Assumes: inc is the number of qualifying occurrences in the current cycle
// Notes:   Wraps silently at full scale
`timescale 1ns/1ns
`default_nettype none
module event_counter
   import mem_event_pkg::*;
(
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // Occurrences this cycle
   input  wire logic [INC_W-1:0]   inc,
   // Running total
   output logic      [COUNT_W-1:0] count
);

   logic [COUNT_W-1:0] next_count;

   assign next_count = count + {{(COUNT_W-INC_W){1'b0}}, inc}; // RULE12

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         count <= COUNT_RESET; // RULE12
      else
         count <= next_count;
   end

   count_reset_a: assert property (@(posedge sys_clk) rst |=> count == COUNT_RESET) // RULE12
      else $error("counter not cleared by reset");

   count_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
      inc == '0 |=> $stable(count))
      else $error("counter moved without an occurrence");

endmodule
`default_nettype wire

// file: src/mem_event_counts.sv
// Purpose: Memory-path event generation, event selection and counting
// Assumes: Event sources, scheduler requests and counter selects are all on sys_clk
// Notes:   A counted event reaches its counter one cycle after it is seen
//
// Behaviour
// [RULE1] Code 31H mask 07H counts priority updates on every channel.
// [RULE2] Isochronous high or critical request matching an issued normal request sends update.
// [RULE3] Code 32H masks 01H, 02H, 04H count retries on channels 0, 1, 2.
// [RULE4] Code 32H mask 07H counts retries from any channel.
// [RULE5] Retries count only while the reliability mode is on.
// [RULE6] Code 33H masks 01H, 02H, 04H count forced acks to hub, remote, local.
// [RULE7] Code 33H mask 07H counts every forced ack message.
// [RULE8] Code 34H mask 01H counts sleeps from hub write-after-read ordering.
// [RULE9] Code 34H masks 02H, 04H count remote and local ordering sleeps.
// [RULE10] Code 34H masks 08H, 10H, 20H count hub, remote, local address sleeps.
// [RULE11] A sleeping request is never issued to the scheduler until woken.
// [RULE12] Each counter adds one per occurrence, clears on reset, stays independent.
`timescale 1ns/1ns
`default_nettype none
module mem_event_counts
   import mem_event_pkg::*;
(
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // Counter selection
   input  wire logic [7:0]               ctr_event_code [NUM_CTR],
   input  wire logic [7:0]               ctr_unit_mask  [NUM_CTR],
   // Normal-priority requests issued to the memory_request_scheduler
   input  wire logic                     issue_valid,
   input  wire logic [SLOT_W-1:0]        issue_slot,
   input  wire logic [TAG_W-1:0]         issue_tag,
   input  wire logic [CHAN_W-1:0]        issue_chan,
   input  wire logic                     retire_valid,
   input  wire logic [SLOT_W-1:0]        retire_slot,
   // Incoming isochronous_class requests
   input  wire logic                     isochronous_class_valid,
   input  wire isochronous_class_e       isochronous_class_class,
   input  wire logic [TAG_W-1:0]         isochronous_class_tag,
   // Retries from the integrated_memory_ctrl
   input  wire logic                     ras_mode,
   input  wire logic [NUM_CHAN-1:0]      retry_chan,
   // Forced ack conflict messages: io_hub, remote home, local home
   input  wire logic [2:0]               forced_ack_sent,
   // Sleep and wake of home_request_logic entries
   input  wire logic                     sleep_valid,
   input  wire logic [SLOT_W-1:0]        sleep_slot,
   input  wire logic [HIT_W-1:0]         sleep_cause,
   input  wire logic                     wake_valid,
   input  wire logic [SLOT_W-1:0]        wake_slot,
   // Scheduling toward the memory_request_scheduler
   input  wire logic                     sched_req_valid,
   input  wire logic [SLOT_W-1:0]        sched_req_slot,
   output logic                          sched_issue_valid,
   output logic      [SLOT_W-1:0]        sched_issue_slot,
   // Priority update toward the memory_request_scheduler
   output logic                          prio_update_valid,
   output logic      [CHAN_W-1:0]        prio_update_chan,
   output logic      [TAG_W-1:0]         prio_update_tag,
   // Counter values
   output logic      [COUNT_W-1:0]       ctr_value [NUM_CTR]
);

   // Occurrences of the event selected by code and mask
   function automatic logic [HIT_W-1:0] select_hits(
      input logic [7:0]          code,
      input logic [7:0]          mask,
      input logic [NUM_CHAN-1:0] upd,
      input logic [NUM_CHAN-1:0] rty,
      input logic [2:0]          ack,
      input logic [HIT_W-1:0]    slp
   );
      logic [HIT_W-1:0] raw;
      raw = '0;
      unique case (code)
         EV_PRIORITY_UPDATE: raw = {3'b000, upd}; // RULE1
         EV_MEM_RETRY:       raw = {3'b000, rty}; // RULE3 RULE4
         EV_FORCED_ACK:      raw = {3'b000, ack}; // RULE6 RULE7
         EV_SLEEP:           raw = slp; // RULE8 RULE9 RULE10
         default:            raw = '0;
      endcase
      return raw & mask[HIT_W-1:0];
   endfunction

   function automatic logic [INC_W-1:0] count_ones(input logic [HIT_W-1:0] v);
      logic [INC_W-1:0] n;
      n = '0;
      for (int i = 0; i < HIT_W; i++)
         n = n + {{(INC_W-1){1'b0}}, v[i]};
      return n;
   endfunction

   // Issued normal-priority requests and sleeping entries
   logic [SLOTS-1:0]  issued;
   logic [TAG_W-1:0]  issued_tag  [SLOTS];
   logic [CHAN_W-1:0] issued_chan [SLOTS];
   logic [SLOTS-1:0]  asleep;
   logic [SLOTS-1:0]  tag_match;

   genvar s;
   generate
      for (s = 0; s < SLOTS; s++)
      begin : g_slot
         logic issue_here;
         logic retire_here;
         logic sleep_here;
         logic wake_here;
         assign issue_here  = issue_valid && issue_slot == SLOT_W'(s);
         assign retire_here = retire_valid && retire_slot == SLOT_W'(s);
         assign sleep_here  = sleep_valid && sleep_slot == SLOT_W'(s);
         assign wake_here   = wake_valid && wake_slot == SLOT_W'(s);
         assign tag_match[s] = issued[s] && issued_tag[s] == isochronous_class_tag;

         // A fresh issue wins over a retire of the same slot
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               issued[s] <= 1'b0;
            else if (issue_here)
               issued[s] <= 1'b1;
            else if (retire_here)
               issued[s] <= 1'b0;
         end

         // Cleared so that the update channel never shows an unknown value
         always_ff @(posedge sys_clk)
         begin
            if (rst)
            begin
               issued_tag[s]  <= '0;
               issued_chan[s] <= '0;
            end
            else if (issue_here)
            begin
               issued_tag[s]  <= issue_tag;
               issued_chan[s] <= issue_chan;
            end
         end

         // Going to sleep wins over a wake in the same cycle so no sleep is lost
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               asleep[s] <= 1'b0;
            else if (sleep_here)
               asleep[s] <= 1'b1; // RULE11
            else if (wake_here)
               asleep[s] <= 1'b0;
         end
      end
   endgenerate

   // Lowest matching slot supplies the channel of the update
   logic [SLOT_W-1:0] match_slot;
   always_comb
   begin
      match_slot = '0;
      for (int i = SLOTS - 1; i >= 0; i--)
         if (tag_match[i])
            match_slot = SLOT_W'(i);
   end

   logic send_update;
   assign send_update = isochronous_class_valid && isochronous_class_class != class_normal && |tag_match; // RULE2

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         prio_update_valid <= 1'b0;
         prio_update_chan  <= '0;
         prio_update_tag   <= '0;
      end
      else
      begin
         prio_update_valid <= send_update; // RULE2
         prio_update_chan  <= issued_chan[match_slot];
         prio_update_tag   <= isochronous_class_tag;
      end
   end

   // A request being put to sleep this cycle is blocked as well
   logic slot_blocked;
   assign slot_blocked = asleep[sched_req_slot]
                         || (sleep_valid && sleep_slot == sched_req_slot);

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sched_issue_valid <= 1'b0;
         sched_issue_slot  <= '0;
      end
      else
      begin
         sched_issue_valid <= sched_req_valid && !slot_blocked; // RULE11
         sched_issue_slot  <= sched_req_slot;
      end
   end

   // Event vectors, registered or decoded from registered outputs, so that the counters see clean pulses
   logic [NUM_CHAN-1:0] upd_hits;
   logic [NUM_CHAN-1:0] rty_hits;
   logic [2:0]          ack_hits;
   logic [HIT_W-1:0]    slp_hits;

   genvar c;
   generate
      for (c = 0; c < NUM_CHAN; c++)
      begin : g_chan
         assign upd_hits[c] = prio_update_valid && prio_update_chan == CHAN_W'(c); // RULE1
      end
   endgenerate

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rty_hits <= '0;
         ack_hits <= '0;
         slp_hits <= '0;
      end
      else
      begin
         // Stray retries outside reliability mode must not skew the counts
         rty_hits <= ras_mode ? retry_chan : '0; // RULE5
         ack_hits <= forced_ack_sent; // RULE6
         slp_hits <= sleep_valid ? sleep_cause : '0; // RULE8 RULE9 RULE10
      end
   end

   genvar k;
   generate
      for (k = 0; k < NUM_CTR; k++)
      begin : g_ctr
         logic [INC_W-1:0] inc;
         assign inc = count_ones(select_hits(ctr_event_code[k], ctr_unit_mask[k],
                                             upd_hits, rty_hits, ack_hits, slp_hits)); // RULE12

         event_counter u_counter (
            .sys_clk (sys_clk),
            .rst     (rst),
            .inc     (inc),
            .count   (ctr_value[k])
         );

         retry_gate_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
            !ras_mode && ctr_event_code[k] == EV_MEM_RETRY
            ##1 ctr_event_code[k] == EV_MEM_RETRY |=> $stable(ctr_value[k]))
            else $error("retry counted while reliability mode off");

         retry_any_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
            ras_mode && retry_chan == 3'b111
            ##1 ctr_event_code[k] == EV_MEM_RETRY && ctr_unit_mask[k] == MASK_ANY_OF_THREE
            |=> ctr_value[k] == $past(ctr_value[k]) + 48'h3)
            else $error("any-channel retry count wrong");

         ack_all_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
            forced_ack_sent == 3'b111
            ##1 ctr_event_code[k] == EV_FORCED_ACK && ctr_unit_mask[k] == MASK_ANY_OF_THREE
            |=> ctr_value[k] == $past(ctr_value[k]) + 48'h3)
            else $error("forced ack total count wrong");

         sleep_hub_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE8
            sleep_valid && sleep_cause == HIT_W'(MASK_FIRST)
            ##1 ctr_event_code[k] == EV_SLEEP && ctr_unit_mask[k] == MASK_FIRST
            |=> ctr_value[k] == $past(ctr_value[k]) + 48'h1)
            else $error("hub ordering sleep not counted once");

         sleep_addr_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
            sleep_valid && sleep_cause == HIT_W'(MASK_LOCAL_ADDR)
            ##1 ctr_event_code[k] == EV_SLEEP && ctr_unit_mask[k] == MASK_HUB_ADDRESS
            |=> $stable(ctr_value[k]))
            else $error("address sleep counted under wrong mask");
      end
   endgenerate

   update_sent_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
      isochronous_class_valid && isochronous_class_class != class_normal && |tag_match
      |=> prio_update_valid && prio_update_tag == $past(isochronous_class_tag))
      else $error("priority update missing after matching request");

   update_normal_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
      !(isochronous_class_valid && isochronous_class_class != class_normal) |=> !prio_update_valid)
      else $error("priority update without high or critical request");

   sleep_block_a: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
      sched_req_valid && asleep[sched_req_slot] |=> !sched_issue_valid)
      else $error("sleeping request issued to scheduler");

   update_count_cover: cover property (@(posedge sys_clk) disable iff (rst)
      prio_update_valid && ctr_event_code[0] == EV_PRIORITY_UPDATE);
   retry_cover: cover property (@(posedge sys_clk) disable iff (rst)
      ras_mode && |retry_chan);
   sleep_wake_cover: cover property (@(posedge sys_clk) disable iff (rst)
      sleep_valid ##[1:20] wake_valid);
   blocked_cover: cover property (@(posedge sys_clk) disable iff (rst)
      sched_req_valid && slot_blocked);

endmodule
`default_nettype wire

// file: verif/ctr_select_model.sv
// Purpose: Counter selection side that programs event code and unit masks
// Assumes: One event code for all counters and one unit mask per counter, loaded together
// Notes:   Code 00H after reset selects nothing, so no counter moves until a load
`timescale 1ns/1ns
`default_nettype none
module ctr_select_model
   import mem_event_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Selection load
   input  wire logic       sel_load,
   input  wire logic [7:0] sel_code,
   input  wire logic [7:0] sel_mask [NUM_CTR],
   // Selection toward the counters
   output logic      [7:0] ctr_event_code [NUM_CTR],
   output logic      [7:0] ctr_unit_mask  [NUM_CTR]
);
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < NUM_CTR; i++)
      begin
         if (rst)
         begin
            ctr_event_code[i] <= 8'h00;
            ctr_unit_mask[i]  <= 8'h00;
         end
         else if (sel_load)
         begin
            ctr_event_code[i] <= sel_code;
            ctr_unit_mask[i]  <= sel_mask[i];
         end
      end
   end
endmodule
`default_nettype wire

// file: verif/mem_event_counts_tb.sv
// Purpose: Self-checking bench for memory-path event selection and counting
// Assumes: Inputs change on the rising edge by non-blocking assignment
// Notes:   Each scenario starts from reset so expected totals begin at zero
`timescale 1ns/1ns
`default_nettype none
module mem_event_counts_tb
   import mem_event_pkg::*;
;
   localparam int LIMIT = 2000;
   logic                     sys_clk, rst, sel_load;
   logic [7:0]               sel_code;
   logic [7:0]               sel_mask [NUM_CTR];
   logic [7:0]               ev_code [NUM_CTR];
   logic [7:0]               ev_mask [NUM_CTR];
   logic                     issue_valid, isochronous_class_valid, ras_mode, sleep_valid, wake_valid;
   logic                     sched_req_valid, sched_issue_valid, prio_update_valid;
   logic [SLOT_W-1:0]        issue_slot, sleep_slot, wake_slot, sched_req_slot, sched_issue_slot;
   logic [TAG_W-1:0]         issue_tag, isochronous_class_tag, prio_update_tag;
   logic [CHAN_W-1:0]        issue_chan, prio_update_chan;
   isochronous_class_e       isochronous_class_class;
   logic [NUM_CHAN-1:0]      retry_chan;
   logic [2:0]               forced_ack_sent;
   logic [HIT_W-1:0]         sleep_cause;
   logic [COUNT_W-1:0]       ctr_value [NUM_CTR];
   int                       errors, compares, cycles;

   ctr_select_model u_ctr_select_model (.sys_clk(sys_clk), .rst(rst), .sel_load(sel_load),
      .sel_code(sel_code), .sel_mask(sel_mask), .ctr_event_code(ev_code),
      .ctr_unit_mask(ev_mask));

   // Retire is left idle: entries are never reused within one scenario
   mem_event_counts u_mem_event_counts (.sys_clk(sys_clk), .rst(rst),
      .ctr_event_code(ev_code), .ctr_unit_mask(ev_mask), .issue_valid(issue_valid),
      .issue_slot(issue_slot), .issue_tag(issue_tag), .issue_chan(issue_chan),
      .retire_valid(1'b0), .retire_slot(3'h0), .isochronous_class_valid(isochronous_class_valid),
      .isochronous_class_class(isochronous_class_class), .isochronous_class_tag(isochronous_class_tag), .ras_mode(ras_mode),
      .retry_chan(retry_chan), .forced_ack_sent(forced_ack_sent), .sleep_valid(sleep_valid),
      .sleep_slot(sleep_slot), .sleep_cause(sleep_cause), .wake_valid(wake_valid),
      .wake_slot(wake_slot), .sched_req_valid(sched_req_valid),
      .sched_req_slot(sched_req_slot), .sched_issue_valid(sched_issue_valid),
      .sched_issue_slot(sched_issue_slot), .prio_update_valid(prio_update_valid),
      .prio_update_chan(prio_update_chan), .prio_update_tag(prio_update_tag),
      .ctr_value(ctr_value));

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         errors = errors + 1;
         close_out();
      end
   end

   task close_out;
      if (errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string name, input logic [COUNT_W-1:0] exp, input logic [COUNT_W-1:0] seen);
      compares = compares + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Counts hold once settled, so a fixed wait past the two-edge latency is safe
   task check_ctrs(input logic [COUNT_W-1:0] e0, e1, e2, e3);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("ctr_value0", e0, ctr_value[0]);
      chk("ctr_value1", e1, ctr_value[1]);
      chk("ctr_value2", e2, ctr_value[2]);
      chk("ctr_value3", e3, ctr_value[3]);
   endtask

   task do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
   endtask

   task select(input logic [7:0] code, m0, m1, m2, m3);
      @(posedge sys_clk);
      sel_load <= 1'b1;
      sel_code <= code;
      sel_mask <= '{m0, m1, m2, m3};
      @(posedge sys_clk);
      sel_load <= 1'b0;
   endtask

   task test_retry;
      do_reset();
      check_ctrs(48'h0, 48'h0, 48'h0, 48'h0);
      select(EV_MEM_RETRY, MASK_FIRST, MASK_SECOND, MASK_THIRD, MASK_ANY_OF_THREE);
      @(posedge sys_clk);
      ras_mode   <= 1'b1;
      retry_chan <= 3'h7;
      @(posedge sys_clk);
      retry_chan <= 3'h0;
      check_ctrs(48'h1, 48'h1, 48'h1, 48'h3);
      @(posedge sys_clk);
      ras_mode   <= 1'b0;
      retry_chan <= 3'h7;
      @(posedge sys_clk);
      retry_chan <= 3'h0;
      check_ctrs(48'h1, 48'h1, 48'h1, 48'h3);
   endtask

   task test_prio;
      do_reset();
      select(EV_PRIORITY_UPDATE, MASK_FIRST, MASK_SECOND, MASK_THIRD, MASK_ANY_OF_THREE);
      @(posedge sys_clk);
      issue_valid <= 1'b1;
      issue_slot  <= 3'h2;
      issue_tag   <= 8'h5A;
      issue_chan  <= 2'h1;
      @(posedge sys_clk);
      issue_valid <= 1'b0;
      isochronous_class_valid  <= 1'b1;
      isochronous_class_class  <= class_high;
      isochronous_class_tag    <= 8'h5A;
      @(posedge sys_clk);
      isochronous_class_class  <= class_normal;
      #1;
      chk("prio_update_valid", 48'h1, prio_update_valid);
      chk("prio_update_chan", 48'h1, prio_update_chan);
      chk("prio_update_tag", 48'h5A, prio_update_tag);
      @(posedge sys_clk);
      isochronous_class_class  <= class_critical;
      #1;
      chk("prio_update_valid", 48'h0, prio_update_valid);
      @(posedge sys_clk);
      isochronous_class_valid  <= 1'b0;
      #1;
      chk("prio_update_valid", 48'h1, prio_update_valid);
      check_ctrs(48'h0, 48'h2, 48'h0, 48'h2);
   endtask

   task test_ack;
      do_reset();
      select(EV_FORCED_ACK, MASK_FIRST, MASK_SECOND, MASK_THIRD, MASK_ANY_OF_THREE);
      @(posedge sys_clk);
      forced_ack_sent <= 3'h5;
      @(posedge sys_clk);
      forced_ack_sent <= 3'h2;
      @(posedge sys_clk);
      forced_ack_sent <= 3'h7;
      @(posedge sys_clk);
      forced_ack_sent <= 3'h0;
      check_ctrs(48'h2, 48'h2, 48'h2, 48'h6);
   endtask

   task sleep_slot_all(input logic [SLOT_W-1:0] slot, input logic [HIT_W-1:0] cause);
      @(posedge sys_clk);
      sleep_valid <= 1'b1;
      sleep_slot  <= slot;
      sleep_cause <= cause;
      @(posedge sys_clk);
      sleep_valid <= 1'b0;
   endtask

   task test_sleep;
      do_reset();
      select(EV_SLEEP, MASK_FIRST, MASK_SECOND, MASK_THIRD, MASK_HUB_ADDRESS);
      sleep_slot_all(3'h5, 6'h01);
      sleep_slot_all(3'h6, 6'h20);
      sleep_slot_all(3'h3, 6'h3F);
      sched_req_valid <= 1'b1;
      sched_req_slot  <= 3'h3;
      @(posedge sys_clk);
      sched_req_valid <= 1'b0;
      #1;
      chk("sched_issue_valid", 48'h0, sched_issue_valid);
      check_ctrs(48'h2, 48'h1, 48'h1, 48'h1);
      select(EV_SLEEP, MASK_REMOTE_ADDR, MASK_LOCAL_ADDR, 8'h3F, 8'h00);
      sleep_slot_all(3'h4, 6'h3F);
      check_ctrs(48'h3, 48'h2, 48'h7, 48'h1);
      @(posedge sys_clk);
      wake_valid <= 1'b1;
      wake_slot  <= 3'h3;
      @(posedge sys_clk);
      wake_valid      <= 1'b0;
      sched_req_valid <= 1'b1;
      @(posedge sys_clk);
      sched_req_valid <= 1'b0;
      #1;
      chk("sched_issue_valid", 48'h1, sched_issue_valid);
      chk("sched_issue_slot", 48'h3, sched_issue_slot);
   endtask

   initial
   begin
      sys_clk = 1'b0;
      rst = 1'b1;
      sel_load = 1'b0;
      sel_code = 8'h00;
      sel_mask = '{8'h00, 8'h00, 8'h00, 8'h00};
      {issue_valid, isochronous_class_valid, ras_mode, sleep_valid, wake_valid, sched_req_valid} = 6'h00;
      {issue_slot, sleep_slot, wake_slot, sched_req_slot} = 12'h000;
      {issue_tag, isochronous_class_tag, issue_chan} = 18'h00000;
      isochronous_class_class = class_normal;
      retry_chan = 3'h0;
      forced_ack_sent = 3'h0;
      sleep_cause = 6'h00;
      errors = 0;
      compares = 0;
      cycles = 0;
      test_retry();
      test_prio();
      test_ack();
      test_sleep();
      do_reset();
      check_ctrs(48'h0, 48'h0, 48'h0, 48'h0);
      close_out();
   end
endmodule
`default_nettype wire
